// ===== ldfs_bridge.sv
// legacy dma forwarding master with serial interrupt driver
`timescale 1ns/1ps
`default_nettype none
module ldfs_bridge #(
    parameter int unsigned NCH = ldfs_pkg::NUM_CH
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // target side: initiator access to legacy dma i/o
    input wire logic tgt_valid_i,
    input wire ldfs_pkg::ldfs_req_t tgt_req_i,
    output logic tgt_done_o,
    output logic tgt_retry_o,
    output logic tgt_pass_o,
    output ldfs_pkg::ldfs_rsp_t tgt_rsp_o,
    // slave base table load
    input wire logic base_we_i,
    input wire logic [ldfs_pkg::CH_W-1:0] base_ch_i,
    input wire logic [ldfs_pkg::ADDR_W-1:0] base_addr_i,
    // arbitration
    output logic bus_req_o,
    input wire logic bus_gnt_i,
    // master side: forwarded i/o cycle
    output logic mst_valid_o,
    output ldfs_pkg::ldfs_req_t mst_req_o,
    input wire logic mst_done_i,
    input wire ldfs_pkg::ldfs_rsp_t mst_rsp_i,
    // interrupt sources and serial wire
    input wire logic [ldfs_pkg::NUM_IRQ-1:0] irq_i,
    input wire logic [ldfs_pkg::NUM_PIRQ-1:0] pirq_n_i,
    input wire logic serirq_i,
    output logic serirq_o,
    output logic serirq_oe_o
);
    // ------------------------------------------------------------
    // slave base table
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_ARB, S_FWD, S_HOLD
    } ldfs_state_t;

    ldfs_state_t state;
    logic [ldfs_pkg::ADDR_W-1:0] base_tab [NCH];
    ldfs_pkg::ldfs_req_t pend;
    ldfs_pkg::ldfs_rsp_t result;
    logic hit_lo;
    logic hit_hi;
    logic hit;
    logic same;
    logic [ldfs_pkg::CH_W-1:0] ch;
    logic [ldfs_pkg::ADDR_W-1:0] offs;
    // channel and offset frozen with the pending access
    logic [ldfs_pkg::CH_W-1:0] pend_ch;
    logic [ldfs_pkg::ADDR_W-1:0] pend_offs;

    // one master keeps a base per slave channel
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NCH; i++) begin
                base_tab[i] <= ldfs_pkg::BASE_RST;
            end
        end else if (base_we_i) begin
            base_tab[base_ch_i] <= base_addr_i;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign hit_lo = tgt_req_i.addr <= ldfs_pkg::LO_TOP;
    assign hit_hi = tgt_req_i.addr >= ldfs_pkg::HI_BASE
                 && tgt_req_i.addr <= ldfs_pkg::HI_TOP;
    assign hit = tgt_valid_i && (hit_lo || hit_hi);
    // channel 4 block uses word-spaced ports; low block is shared
    assign ch = hit_hi ? 3'h4 : 3'h0;
    assign offs = hit_hi
        ? (tgt_req_i.addr - ldfs_pkg::HI_BASE) & ldfs_pkg::HI_CH_MASK
        : (tgt_req_i.addr - ldfs_pkg::LO_BASE) & ldfs_pkg::LO_CH_MASK;
    assign same = tgt_req_i == pend;

    // ------------------------------------------------------------
    // forwarding sequence
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            pend <= '0;
            pend_ch <= '0;
            pend_offs <= '0;
            result <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (hit) begin
                        pend <= tgt_req_i;
                        pend_ch <= ch;
                        pend_offs <= offs;
                        state <= S_ARB;
                    end
                end
                S_ARB: begin
                    if (bus_gnt_i) begin
                        state <= S_FWD;
                    end
                end
                S_FWD: begin
                    if (mst_done_i) begin
                        result <= mst_rsp_i;
                        state <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (hit && same) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // target answers, all registered
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tgt_done_o <= 1'b0;
            tgt_retry_o <= 1'b0;
            tgt_pass_o <= 1'b0;
            tgt_rsp_o <= '0;
        end else begin
            tgt_done_o <= hit && state == S_HOLD && same;
            tgt_retry_o <= hit && !(state == S_HOLD && same);
            tgt_pass_o <= tgt_valid_i && !hit;
            tgt_rsp_o <= result;
        end
    end

    // forwarded cycle: plain pci i/o to slave base, no sideband
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bus_req_o <= 1'b0;
            mst_valid_o <= 1'b0;
            mst_req_o <= '0;
        end else begin
            bus_req_o <= state == S_ARB && !bus_gnt_i;
            // valid stands until the slave finishes; a pulse would hang
            if (state == S_ARB && bus_gnt_i) begin
                mst_valid_o <= 1'b1;
                mst_req_o <= pend;
                mst_req_o.addr <= base_tab[pend_ch] + pend_offs;
            end else if (mst_done_i) begin
                mst_valid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // serial interrupt frames
    // ------------------------------------------------------------
    ldfs_serirq #(
        .NIRQ(ldfs_pkg::NUM_IRQ)
    ) u_serirq (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .irq_i(irq_i),
        .pirq_n_i(pirq_n_i),
        .serirq_i(serirq_i),
        .serirq_o(serirq_o),
        .serirq_oe_o(serirq_oe_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_granted;
        state == S_ARB && bus_gnt_i;
    endsequence
    sequence s_forward;
        ##1 mst_valid_o && mst_req_o.write == pend.write;
    endsequence
    sequence s_finish;
        state == S_FWD && mst_done_i;
    endsequence


    a_retry_first: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) state == S_IDLE && hit |=> tgt_retry_o)
        else $error("legacy access not retried");
    a_grant_fwd: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) s_granted |-> s_forward)
        else $error("grant not followed by forward");
    a_no_fwd_nogrant: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) $rose(mst_valid_o) |-> $past(bus_gnt_i))
        else $error("forward without grant");
    a_retry_until_done: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) state != S_HOLD && hit |=> !tgt_done_o)
        else $error("completed before forward end");
    a_done_result: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) tgt_done_o |-> tgt_rsp_o == result)
        else $error("completion lacks slave result");
    a_done_excl: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) !(tgt_done_o && tgt_retry_o))
        else $error("done and retry together");
    a_base_kept: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) base_we_i |=>
        base_tab[$past(base_ch_i)] == $past(base_addr_i))
        else $error("slave base not stored");
    a_req_drop: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) bus_req_o |-> state == S_ARB)
        else $error("bus request outside arbitration");
    // a slow slave hangs the bridge if the forward drops early
    a_valid_held: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) mst_valid_o && !mst_done_i |=> mst_valid_o)
        else $error("forward dropped before slave done");
    a_fwd_finish: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) s_finish |=> state == S_HOLD && !mst_valid_o)
        else $error("slave finish not taken");
    a_hold_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) state == S_HOLD |-> !mst_valid_o && !bus_req_o)
        else $error("bus busy while holding result");
    a_pass_quiet: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        tgt_valid_i && !hit |=> tgt_pass_o && !tgt_retry_o)
        else $error("foreign access claimed");
endmodule
`default_nettype wire

// ===== ldfs_pkg.sv
// package: constants and carriers for legacy dma forwarding and serial irq
// Behaviour
// - one master keeps each slave's base address
// - legacy dma i/o accesses get pci retry
// - after retry, arbitrate and forward to slave
// - only existing pci signalling, no sideband wires
// - one shared serial interrupt wire
// - sixteen legacy irqs plus inta to intd
package ldfs_pkg;
    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned CH_W = 3;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_IRQ = 16;
    localparam int unsigned NUM_PIRQ = 4;
    localparam int unsigned NUM_FRAMES = 20;
    localparam int unsigned FRAME_W = 5;
    localparam int unsigned SLOT_W = 2;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 2'h2;
    localparam logic [FRAME_W-1:0] FRAME_LAST = 5'h13;
    // ------------------------------------------------------------
    // legacy dma i/o decode (channel 0-3 block, channel 4-7 block)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LO_BASE = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] LO_TOP = 32'h0000_000f;
    localparam logic [ADDR_W-1:0] HI_BASE = 32'h0000_00c0;
    localparam logic [ADDR_W-1:0] HI_TOP = 32'h0000_00df;
    localparam logic [ADDR_W-1:0] LO_CH_MASK = 32'h0000_000f;
    localparam logic [ADDR_W-1:0] HI_CH_MASK = 32'h0000_001f;
    localparam logic [ADDR_W-1:0] BASE_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] be;
        logic write;
    } ldfs_req_t;
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic error;
    } ldfs_rsp_t;
endpackage

// ===== ldfs_serirq.sv
// serial interrupt frame driver on one shared wire
`timescale 1ns/1ps
`default_nettype none
module ldfs_serirq #(
    parameter int unsigned NIRQ = ldfs_pkg::NUM_IRQ
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // interrupt sources
    input wire logic [NIRQ-1:0] irq_i,
    input wire logic [ldfs_pkg::NUM_PIRQ-1:0] pirq_n_i,
    // shared serial wire
    input wire logic serirq_i,
    output logic serirq_o,
    output logic serirq_oe_o
);
    // ------------------------------------------------------------
    // continuous frame: 3 clocks per source frame, 20 frames then wrap, no start slot
    // ------------------------------------------------------------
    logic [ldfs_pkg::FRAME_W-1:0] frame;
    logic [ldfs_pkg::SLOT_W-1:0] slot;
    logic [ldfs_pkg::NUM_FRAMES-1:0] req;
    logic unused_in;

    // legacy irqs then inta..intd in one frame sequence
    assign req = {~pirq_n_i, irq_i};
    assign unused_in = serirq_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            slot <= '0;
            frame <= '0;
        end else if (slot == ldfs_pkg::SLOT_LAST) begin
            slot <= '0;
            frame <= (frame == ldfs_pkg::FRAME_LAST) ? '0
                   : frame + 5'h01;
        end else begin
            slot <= slot + 2'h1;
        end
    end

    // low in first slot of an active frame, then drive high once
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            serirq_o <= 1'b1;
            serirq_oe_o <= 1'b0;
        end else begin
            serirq_o <= !(slot == '0 && req[frame]);
            serirq_oe_o <= (slot != ldfs_pkg::SLOT_LAST) && req[frame];
        end
    end

    a_slot_bound: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) slot <= ldfs_pkg::SLOT_LAST)
        else $error("serial slot out of range");
    a_drive_low_oe: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i) !serirq_o |-> serirq_oe_o)
        else $error("low driven without enable");
endmodule
`default_nettype wire

// ===== ldfs_slave_model.sv
// slave dma device and arbiter model for the forwarded i/o cycles
`timescale 1ns/1ps
`default_nettype none
module ldfs_slave_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // answer delay in cycles, at most 15
    input wire logic [3:0] dly_i,
    // arbitration
    input wire logic bus_req_i,
    output logic bus_gnt_o,
    // forwarded cycle
    input wire logic mst_valid_i,
    input wire ldfs_pkg::ldfs_req_t mst_req_i,
    output logic mst_done_o,
    output ldfs_pkg::ldfs_rsp_t mst_rsp_o
);
    logic [3:0] gcnt;
    logic [3:0] dcnt;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !bus_req_i) begin
            gcnt <= 4'h0;
            bus_gnt_o <= 1'b0;
        end else begin
            gcnt <= gcnt + 4'h1;
            bus_gnt_o <= (gcnt >= dly_i);
        end
    end
    // -----------------------------------------
    // slave: answers every forwarded cycle; error set outside its own bases
    // -----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !mst_valid_i) begin
            dcnt <= 4'h0;
            mst_done_o <= 1'b0;
        end else begin
            dcnt <= (dcnt == dly_i) ? 4'hf : dcnt + {3'h0, dcnt != 4'hf};
            mst_done_o <= (dcnt == dly_i);
        end
    end
    // stale result toggles every cycle, so a read one cycle late does not match
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mst_rsp_o <= '0;
        end else if (mst_valid_i && dcnt == dly_i) begin
            mst_rsp_o.rdata <= {mst_req_i.addr[15:0], 16'hc35a};
            mst_rsp_o.error <=
                !(mst_req_i.addr[31:12] inside {20'h1, 20'h2});
        end else begin
            mst_rsp_o <= ~mst_rsp_o;
        end
    end
endmodule
`default_nettype wire

// ===== ldfs_bridge_tb_top.sv
// self-checking bench for the legacy dma forwarding bridge
`timescale 1ns/1ps
`default_nettype none
module ldfs_bridge_tb_top;
    logic sys_clk_i, rst_n_i, tgt_valid_i, tgt_done_o, tgt_retry_o, tgt_pass_o;
    logic base_we_i, bus_req_o, bus_gnt_i, mst_valid_o, mst_done_i;
    logic serirq_o, serirq_oe_o;
    logic [2:0] base_ch_i;
    logic [31:0] base_addr_i;
    logic [15:0] irq_i;
    logic [3:0] pirq_n_i;
    logic [3:0] dly;
    ldfs_pkg::ldfs_req_t tgt_req_i, mst_req_o;
    ldfs_pkg::ldfs_rsp_t tgt_rsp_o, mst_rsp_i, rsp_seen;
    int n_mismatch = 0, num_checks = 0, cyc = 0, p0 = 0;
    // shared wire has a pull-up when nobody drives it
    wire logic serirq_w = serirq_oe_o ? serirq_o : 1'b1;

    ldfs_bridge uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .tgt_valid_i(tgt_valid_i), .tgt_req_i(tgt_req_i),
        .tgt_done_o(tgt_done_o), .tgt_retry_o(tgt_retry_o),
        .tgt_pass_o(tgt_pass_o), .tgt_rsp_o(tgt_rsp_o),
        .base_we_i(base_we_i), .base_ch_i(base_ch_i),
        .base_addr_i(base_addr_i), .bus_req_o(bus_req_o),
        .bus_gnt_i(bus_gnt_i), .mst_valid_o(mst_valid_o),
        .mst_req_o(mst_req_o), .mst_done_i(mst_done_i),
        .mst_rsp_i(mst_rsp_i), .irq_i(irq_i), .pirq_n_i(pirq_n_i),
        .serirq_i(serirq_w), .serirq_o(serirq_o),
        .serirq_oe_o(serirq_oe_o));
    ldfs_slave_model slv (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .dly_i(dly), .bus_req_i(bus_req_o), .bus_gnt_o(bus_gnt_i),
        .mst_valid_i(mst_valid_o), .mst_req_i(mst_req_o),
        .mst_done_o(mst_done_i), .mst_rsp_o(mst_rsp_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one-cycle access, answer gathered over the following cycles
    task automatic access(input logic [31:0] a, input logic w,
                          output logic [2:0] ans);
        ans = 3'h0;
        @(negedge sys_clk_i);
        tgt_req_i = '{a, 32'h1234_abcd ^ a, 4'hf, w};
        tgt_valid_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk_i);
            tgt_valid_i = 1'b0;
            if (ans == 3'h0) begin
                ans = {tgt_done_o, tgt_retry_o, tgt_pass_o};
                rsp_seen = tgt_rsp_o;
            end
        end
    endtask
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic t_pass(input logic [31:0] a);
        logic [2:0] ans;
        access(a, 1'b0, ans);
        check(ans, 3'h1);
        check(bus_req_o, 1'b0);
        $display("test pass %h done", a);
    endtask
    task automatic t_fwd(input logic [31:0] a, input logic [31:0] f,
                         input logic w, input logic [3:0] d);
        logic [2:0] ans;
        int n;
        dly = d;
        access(a, w, ans);
        check(ans, 3'h2);
        check(bus_req_o | mst_valid_o, 1'b1);
        n = 0;
        while (!mst_valid_o && n < 40) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(mst_req_o, {f, 32'h1234_abcd ^ a, 4'hf, w});
        access(a, w, ans);
        check(ans, 3'h2);
        access(a ^ 32'h1, w, ans);
        check(ans, 3'h2);
        while (mst_valid_o && n < 80) begin
            @(negedge sys_clk_i);
            n++;
        end
        access(a, w, ans);
        check(ans, 3'h4);
        check(rsp_seen, {f[15:0], 16'hc35a, 1'b0});
        $display("test forward %h done", a);
    endtask
    task automatic t_irq(input logic [19:0] m);
        logic [19:0] got;
        logic pl;
        int p;
        irq_i = m[15:0];
        pirq_n_i = ~m[19:16];
        repeat (70) @(negedge sys_clk_i);
        got = '0;
        pl = 1'b0;
        repeat (60) begin
            @(negedge sys_clk_i);
            p = (cyc - p0) % 60;
            if (pl) check({serirq_oe_o, serirq_w}, 2'h3);
            pl = serirq_oe_o && !serirq_o;
            if (pl) begin
                got[p / 3] = 1'b1;
                check(p % 3, 0);
            end
        end
        check(got, m);
        $display("test irq %h done", m);
    endtask

    initial begin
        rst_n_i = 1'b0;
        tgt_valid_i = 1'b0;
        tgt_req_i = '0;
        base_we_i = 1'b0;
        base_ch_i = 3'h0;
        base_addr_i = 32'h0;
        irq_i = 16'h1;
        pirq_n_i = 4'hf;
        dly = 4'h2;
        repeat (4) @(negedge sys_clk_i);
        check({tgt_done_o, tgt_retry_o, tgt_pass_o, bus_req_o, mst_valid_o,
               serirq_o}, 6'h01);
        rst_n_i = 1'b1;
        base_we_i = 1'b1;
        base_addr_i = 32'h0000_1000;
        @(negedge sys_clk_i);
        base_ch_i = 3'h4;
        base_addr_i = 32'h0000_2000;
        @(negedge sys_clk_i);
        base_we_i = 1'b0;
        // frame 0 anchors the phase of the serial frames
        while (!(serirq_oe_o && !serirq_o) && cyc < 200)
            @(negedge sys_clk_i);
        p0 = cyc;
        t_pass(32'h10);
        t_pass(32'hbf);
        t_pass(32'he0);
        t_fwd(32'h0f, 32'h0000_100f, 1'b1, 4'h6);
        t_fwd(32'hc0, 32'h0000_2000, 1'b0, 4'h8);
        t_fwd(32'hdf, 32'h0000_201f, 1'b1, 4'h7);
        t_irq(20'h0_0001);
        t_irq(20'h8_0421);
        t_irq(20'h6_8000);
        t_irq(20'hf_ffff);
        complete_run();
    end
endmodule
`default_nettype wire
